/* hw/edmoc_top.sv */
// Ethernet DMA operation-mode control: run/stop, flags, thresholds, flush
`timescale 1ns/1ns
`default_nettype none
module edmoc_top
#(
	parameter int RX_FIFO_BYTES = 4096,
	parameter int POS_W = 8
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [15:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic txd_req_o,
	input wire logic txd_valid_i,
	input wire logic txd_owned_i,
	input wire logic tx_queued_i,
	input wire logic tx_frame_done_i,
	input wire logic tx_done_irq_i,
	output logic [POS_W-1:0] tx_pos_o,
	input wire logic [11:0] tx_level_i,
	input wire logic tx_complete_i,
	output logic tx_start_o,
	output logic tx_fifo_flush_o,
	input wire logic txf_empty_i,
	input wire logic tx_stat_pend_i,
	input wire logic tx_clk_ok_i,
	output logic rxd_req_o,
	input wire logic rxd_valid_i,
	input wire logic rxd_owned_i,
	input wire logic rx_frame_start_i,
	input wire logic rx_frame_end_i,
	input wire edmoc_pkg::edmoc_rxst_t rx_status_i,
	output logic [POS_W-1:0] rx_pos_o,
	output logic rx_drop_o,
	output logic rx_flush_o,
	input wire logic [12:0] rx_level_i,
	input wire logic rx_complete_i,
	output logic rx_req_o,
	input wire logic [12:0] rx_fill_i,
	output logic flow_on_o
);
	import edmoc_pkg::*;

	typedef enum logic [4:0] {
		TX_STOP = 5'h01,
		TX_FETCH = 5'h02,
		TX_QUEUE = 5'h04,
		TX_WAIT = 5'h08,
		TX_SUSP = 5'h10
	} edmoc_tx_t;
	typedef enum logic [4:0] {
		RX_STOP = 5'h01,
		RX_FETCH = 5'h02,
		RX_WAIT = 5'h04,
		RX_XFER = 5'h08,
		RX_SUSP = 5'h10
	} edmoc_rx_t;

	if (RX_FIFO_BYTES < 4096 || RX_FIFO_BYTES > 8191 || POS_W < 1) begin : g_bad_param
		$error("edmoc_top: unsupported parameters");
	end

	logic [31:0] mode;
	logic [31:0] status;
	edmoc_tx_t tx_st;
	edmoc_tx_t next_tx_st;
	edmoc_rx_t rx_st;
	edmoc_rx_t next_rx_st;
	logic tx_done_f, tx_stop_f, tx_unav_f, rx_unav_f, rx_stop_f;
	logic wr_mode, wr_stat, tx_poll, rx_poll, flush_done;
	logic [2:0] tx_code, rx_code;
	logic [12:0] trig_lvl, rel_lvl;

	assign wr_mode = ce_i & wr_i & (addr_i == MODE_ADDR);
	assign wr_stat = ce_i & wr_i & (addr_i == STAT_ADDR);
	assign tx_poll = ce_i & wr_i & (addr_i == TXPOLL_ADDR);
	assign rx_poll = ce_i & wr_i & (addr_i == RXPOLL_ADDR);
	assign flush_done = mode[B_FLUSH] & txf_empty_i & ~tx_stat_pend_i & tx_clk_ok_i;

	// Mode register; flush bit self-clears, a fresh write wins
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode <= MODE_RESET;
		end else if (wr_mode) begin
			mode <= wdata_i & MODE_RW_MASK;
		end else if (ce_i && flush_done) begin
			mode[B_FLUSH] <= 1'b0;
		end
	end

	// Transmit process
	always_comb begin
		next_tx_st = tx_st;
		case (tx_st)
			TX_STOP: if (mode[B_TX_RUN]) next_tx_st = TX_FETCH;
			TX_FETCH: begin
				if (!mode[B_TX_RUN])
					next_tx_st = TX_STOP;
				else if (txd_valid_i)
					next_tx_st = txd_owned_i ? TX_QUEUE : TX_SUSP;
			end
			TX_QUEUE: begin
				if (tx_queued_i)
					next_tx_st = mode[B_OVERLAP] ? TX_FETCH : TX_WAIT;
			end
			TX_WAIT: begin
				if (tx_frame_done_i)
					next_tx_st = mode[B_TX_RUN] ? TX_FETCH : TX_STOP;
			end
			TX_SUSP: begin
				if (!mode[B_TX_RUN])
					next_tx_st = TX_STOP;
				else if (tx_poll)
					next_tx_st = TX_FETCH;
			end
			default: next_tx_st = TX_STOP;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_st <= TX_STOP;
		end else if (ce_i) begin
			tx_st <= next_tx_st;
		end
	end

	// Descriptor position survives stop so restart resumes there
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_pos_o <= '0;
		end else if (ce_i && tx_st == TX_QUEUE && tx_queued_i) begin
			tx_pos_o <= tx_pos_o + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			txd_req_o <= 1'b0;
		end else if (ce_i) begin
			txd_req_o <= (next_tx_st == TX_FETCH);
		end
	end

	// Sticky flags: hardware set wins over write-one clear
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_unav_f <= 1'b0;
			tx_stop_f <= 1'b0;
			tx_done_f <= 1'b0;
			rx_unav_f <= 1'b0;
			rx_stop_f <= 1'b0;
		end else if (ce_i) begin
			if (tx_st == TX_FETCH && next_tx_st == TX_SUSP)
				tx_unav_f <= 1'b1;
			else if (wr_stat && wdata_i[S_TX_UNAV])
				tx_unav_f <= 1'b0;
			if (tx_st != TX_STOP && next_tx_st == TX_STOP)
				tx_stop_f <= 1'b1;
			else if (wr_stat && wdata_i[S_TX_STOP])
				tx_stop_f <= 1'b0;
			if (tx_frame_done_i && tx_done_irq_i)
				tx_done_f <= 1'b1;
			else if (wr_stat && wdata_i[S_TX_DONE])
				tx_done_f <= 1'b0;
			if (rx_st == RX_FETCH && next_rx_st == RX_SUSP)
				rx_unav_f <= 1'b1;
			else if (wr_stat && wdata_i[S_RX_UNAV])
				rx_unav_f <= 1'b0;
			if (rx_st != RX_STOP && next_rx_st == RX_STOP)
				rx_stop_f <= 1'b1;
			else if (wr_stat && wdata_i[S_RX_STOP])
				rx_stop_f <= 1'b0;
		end
	end

	// Transmit start: whole frame or above threshold
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_start_o <= 1'b0;
		end else if (ce_i) begin
			if (mode[B_TX_WHOLE])
				tx_start_o <= tx_complete_i;
			else
				tx_start_o <= tx_complete_i |
					(tx_level_i > edmoc_tx_thr(mode[B_TTC_LO+:3]));
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_fifo_flush_o <= 1'b0;
		end else if (ce_i) begin
			tx_fifo_flush_o <= mode[B_FLUSH] & ~flush_done;
		end
	end

	// Receive process
	always_comb begin
		next_rx_st = rx_st;
		case (rx_st)
			RX_STOP: if (mode[B_RX_RUN]) next_rx_st = RX_FETCH;
			RX_FETCH: begin
				if (rxd_valid_i)
					next_rx_st = rxd_owned_i ? RX_WAIT : RX_SUSP;
			end
			RX_WAIT: begin
				if (!mode[B_RX_RUN])
					next_rx_st = RX_STOP;
				else if (rx_frame_start_i)
					next_rx_st = RX_XFER;
			end
			RX_XFER: begin
				if (rx_frame_end_i)
					next_rx_st = RX_FETCH;
			end
			RX_SUSP: begin
				if (!mode[B_RX_RUN])
					next_rx_st = RX_STOP;
				else if (rx_poll || rx_frame_start_i)
					next_rx_st = RX_FETCH;
			end
			default: next_rx_st = RX_STOP;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_st <= RX_STOP;
		end else if (ce_i) begin
			rx_st <= next_rx_st;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_pos_o <= '0;
		end else if (ce_i && rx_st == RX_XFER && rx_frame_end_i) begin
			rx_pos_o <= rx_pos_o + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rxd_req_o <= 1'b0;
		end else if (ce_i) begin
			rxd_req_o <= (next_rx_st == RX_FETCH);
		end
	end

	// Frames ending while suspended are flushed unless kept
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_flush_o <= 1'b0;
		end else if (ce_i) begin
			rx_flush_o <= rx_frame_end_i & (rx_st == RX_SUSP) &
				~mode[B_KEEP_NODESC];
		end
	end

	// Drop decision, one cycle after frame end
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_drop_o <= 1'b0;
		end else if (ce_i) begin
			rx_drop_o <= rx_frame_end_i & (
				rx_status_i.ovf_partial |
				(rx_status_i.err & rx_status_i.runt & mode[B_PASS_ERR]) |
				(rx_status_i.err & ~mode[B_PASS_ERR] & ~rx_status_i.started &
					~(mode[B_KEEP_CSUM] & rx_status_i.csum_only)) |
				(rx_status_i.short_good & ~rx_status_i.err &
					~mode[B_PASS_SHORT] & ~rx_status_i.started));
		end
	end

	// Receive transfer request
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_req_o <= 1'b0;
		end else if (ce_i) begin
			if (mode[B_RX_WHOLE])
				rx_req_o <= rx_complete_i;
			else
				rx_req_o <= rx_complete_i |
					(rx_level_i > edmoc_rx_thr(mode[B_RTC_LO+:2]));
		end
	end

	// Fill-level flow control with hysteresis
	assign trig_lvl = 13'(RX_FIFO_BYTES) - 13'(({11'h0, mode[B_TRIG_LO+:2]} + 13'h1) * KB);
	assign rel_lvl = 13'(RX_FIFO_BYTES) - 13'(({11'h0, mode[B_REL_LO+:2]} + 13'h1) * KB);

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flow_on_o <= 1'b0;
		end else if (ce_i) begin
			if (!mode[B_FLOW_EN])
				flow_on_o <= 1'b0;
			else if (!flow_on_o && rx_fill_i >= trig_lvl)
				flow_on_o <= 1'b1;
			else if (flow_on_o && rx_fill_i <= rel_lvl)
				flow_on_o <= 1'b0;
		end
	end

	// Status view and read port
	always_comb begin
		case (tx_st)
			TX_FETCH: tx_code = 3'h1;
			TX_WAIT: tx_code = 3'h2;
			TX_QUEUE: tx_code = 3'h3;
			TX_SUSP: tx_code = 3'h6;
			default: tx_code = 3'h0;
		endcase
		case (rx_st)
			RX_FETCH: rx_code = 3'h1;
			RX_WAIT: rx_code = 3'h3;
			RX_SUSP: rx_code = 3'h4;
			RX_XFER: rx_code = 3'h7;
			default: rx_code = 3'h0;
		endcase
		status = 32'h0;
		status[S_TX_DONE] = tx_done_f;
		status[S_TX_STOP] = tx_stop_f;
		status[S_TX_UNAV] = tx_unav_f;
		status[S_RX_UNAV] = rx_unav_f;
		status[S_RX_STOP] = rx_stop_f;
		status[S_RX_ST_LO+:3] = rx_code;
		status[S_TX_ST_LO+:3] = tx_code;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= 32'h0;
		end else if (ce_i) begin
			if (rd_i && addr_i == MODE_ADDR)
				rdata_o <= mode;
			else if (rd_i && addr_i == STAT_ADDR)
				rdata_o <= status;
			else
				rdata_o <= 32'h0;
		end
	end

	property p_tu;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && tx_st == TX_FETCH && mode[B_TX_RUN] && txd_valid_i && !txd_owned_i
		|=> tx_unav_f && tx_st == TX_SUSP;
	endproperty
	a_tu: assert property (p_tu) else $error("unavailable flag not set");

	property p_tps;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && $changed(tx_st) && tx_st == TX_STOP |-> tx_stop_f;
	endproperty
	a_tps: assert property (p_tps) else $error("stopped flag missing");

	property p_ti;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && tx_frame_done_i && tx_done_irq_i |=> tx_done_f;
	endproperty
	a_ti: assert property (p_ti) else $error("done flag missing");

	property p_tsf;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && mode[B_TX_WHOLE] && !tx_complete_i |=> !tx_start_o;
	endproperty
	a_tsf: assert property (p_tsf) else $error("start before whole frame");

	property p_ftf;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && !wr_mode && mode[B_FLUSH] && !(txf_empty_i && !tx_stat_pend_i && tx_clk_ok_i)
		|=> mode[B_FLUSH];
	endproperty
	a_ftf: assert property (p_ftf) else $error("flush ended early");

	property p_ftf_clr;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && !wr_mode && flush_done |=> !mode[B_FLUSH] ##1 !tx_fifo_flush_o;
	endproperty
	a_ftf_clr: assert property (p_ftf_clr) else $error("flush not cleared");

	property p_efc;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && !mode[B_FLOW_EN] |=> !flow_on_o;
	endproperty
	a_efc: assert property (p_efc) else $error("flow on while disabled");

	property p_rfd;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && mode[B_FLOW_EN] && !flow_on_o && rx_fill_i < trig_lvl |=> !flow_on_o;
	endproperty
	a_rfd: assert property (p_rfd) else $error("flow before trigger");

	property p_sr;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && rx_st == RX_XFER && !rx_frame_end_i |=> rx_st == RX_XFER;
	endproperty
	a_sr: assert property (p_sr) else $error("rx left mid-frame");

	property p_rxon;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && rx_st == RX_STOP && mode[B_RX_RUN] |=> rx_st == RX_FETCH ##0 rxd_req_o;
	endproperty
	a_rxon: assert property (p_rxon) else $error("rx start lost");

	property p_ovf;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		ce_i && rx_frame_end_i && rx_status_i.ovf_partial |=> rx_drop_o;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow frame kept");
endmodule : edmoc_top
`default_nettype wire

/* hw/edmoc_pkg.sv */
// Package: register map, field positions and threshold tables
package edmoc_pkg;
	localparam logic [15:0] MODE_ADDR = 16'h1018;
	localparam logic [15:0] STAT_ADDR = 16'h1014;
	localparam logic [15:0] TXPOLL_ADDR = 16'h1004;
	localparam logic [15:0] RXPOLL_ADDR = 16'h1008;
	localparam logic [31:0] MODE_RW_MASK = 32'h0731ffde;
	localparam logic [31:0] MODE_RESET = 32'h00000000;
	localparam int B_KEEP_CSUM = 26;
	localparam int B_RX_WHOLE = 25;
	localparam int B_KEEP_NODESC = 24;
	localparam int B_TX_WHOLE = 21;
	localparam int B_FLUSH = 20;
	localparam int B_TTC_LO = 14;
	localparam int B_TX_RUN = 13;
	localparam int B_REL_LO = 11;
	localparam int B_TRIG_LO = 9;
	localparam int B_FLOW_EN = 8;
	localparam int B_PASS_ERR = 7;
	localparam int B_PASS_SHORT = 6;
	localparam int B_RTC_LO = 3;
	localparam int B_OVERLAP = 2;
	localparam int B_RX_RUN = 1;
	localparam int S_TX_DONE = 0;
	localparam int S_TX_STOP = 1;
	localparam int S_TX_UNAV = 2;
	localparam int S_RX_UNAV = 7;
	localparam int S_RX_STOP = 8;
	localparam int S_RX_ST_LO = 17;
	localparam int S_TX_ST_LO = 20;
	localparam logic [12:0] KB = 13'h0400;
	typedef struct packed {
		logic err;
		logic csum_only;
		logic runt;
		logic short_good;
		logic ovf_partial;
		logic started;
	} edmoc_rxst_t;
	function automatic logic [11:0] edmoc_tx_thr(input logic [2:0] c);
		case (c)
			3'h0: edmoc_tx_thr = 12'h040;
			3'h1: edmoc_tx_thr = 12'h080;
			3'h2: edmoc_tx_thr = 12'h0c0;
			3'h3: edmoc_tx_thr = 12'h100;
			3'h4: edmoc_tx_thr = 12'h028;
			3'h5: edmoc_tx_thr = 12'h020;
			3'h6: edmoc_tx_thr = 12'h018;
			default: edmoc_tx_thr = 12'h010;
		endcase
	endfunction : edmoc_tx_thr
	function automatic logic [12:0] edmoc_rx_thr(input logic [1:0] c);
		case (c)
			2'h0: edmoc_rx_thr = 13'h0040;
			2'h1: edmoc_rx_thr = 13'h0020;
			2'h2: edmoc_rx_thr = 13'h0060;
			default: edmoc_rx_thr = 13'h0080;
		endcase
	endfunction : edmoc_rx_thr
endpackage : edmoc_pkg

/* testbench/edmoc_host_model.sv */
// Host-side model: answers descriptor fetches with ownership after a chosen latency
`timescale 1ns/1ns
`default_nettype none
module edmoc_host_model (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic txd_req_i,
	input wire logic rxd_req_i,
	input wire logic tx_own_i,
	input wire logic rx_own_i,
	input wire logic [3:0] lat_i,
	output logic txd_valid_o,
	output logic txd_owned_o,
	output logic rxd_valid_o,
	output logic rxd_owned_o
);
	logic [1:0] vld;
	logic [3:0] cnt [2];
	logic [1:0] req;
	assign req = {rxd_req_i, txd_req_i};
	assign txd_valid_o = vld[0];
	assign rxd_valid_o = vld[1];
	// Ownership only means something with the answer; otherwise the line shows the inverted ownership value
	assign txd_owned_o = vld[0] ? tx_own_i : !tx_own_i;
	assign rxd_owned_o = vld[1] ? rx_own_i : !rx_own_i;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		for (int k = 0; k < 2; k++) begin
			if (!nrst_i) begin
				vld[k] <= 1'b0;
				cnt[k] <= 4'h0;
			end else if (req[k] && !vld[k] && cnt[k] >= lat_i) begin
				vld[k] <= 1'b1;
				cnt[k] <= 4'h0;
			end else begin
				vld[k] <= 1'b0;
				cnt[k] <= (req[k] && !vld[k]) ? cnt[k] + 4'h1 : 4'h0;
			end
		end
	end
endmodule : edmoc_host_model
`default_nettype wire

/* testbench/test_eth_dma_operation_mode_control.sv */
// Testbench for the Ethernet DMA operation-mode control block
`timescale 1ns/1ns
`default_nettype none
module test_eth_dma_operation_mode_control;
	import edmoc_pkg::*;
	logic ref_clk_i, nrst_i, ce_i, wr_i, rd_i, txd_req_o, txd_valid_i, txd_owned_i;
	logic tx_queued_i, tx_frame_done_i, tx_done_irq_i, tx_complete_i, tx_start_o;
	logic tx_fifo_flush_o, txf_empty_i, tx_stat_pend_i, tx_clk_ok_i, rxd_req_o;
	logic rxd_valid_i, rxd_owned_i, rx_frame_start_i, rx_frame_end_i, rx_drop_o;
	logic rx_flush_o, rx_complete_i, rx_req_o, flow_on_o, tx_own, rx_own;
	logic [15:0] addr_i;
	logic [31:0] wdata_i, rdata_o, v;
	logic [7:0] tx_pos_o, rx_pos_o;
	logic [11:0] tx_level_i;
	logic [12:0] rx_level_i, rx_fill_i;
	logic [3:0] lat;
	edmoc_rxst_t rx_status_i;
	int fail_count = 0;
	int compares = 0;
	int tt [8] = '{64, 128, 192, 256, 40, 32, 24, 16};
	int rr [4] = '{64, 32, 96, 128};
	logic [31:0] dm [8] = '{0, 32'h80, 32'h80, 0, 32'h4000000, 0, 32'h40, 32'h80};
	logic [5:0] ds [8] = '{6'h20, 6'h20, 6'h22, 6'h21, 6'h30, 6'h04, 6'h04, 6'h28};
	logic [7:0] de = 8'ha5;
	edmoc_top edmoc_top_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.txd_req_o(txd_req_o), .txd_valid_i(txd_valid_i), .txd_owned_i(txd_owned_i),
		.tx_queued_i(tx_queued_i), .tx_frame_done_i(tx_frame_done_i),
		.tx_done_irq_i(tx_done_irq_i), .tx_pos_o(tx_pos_o), .tx_level_i(tx_level_i),
		.tx_complete_i(tx_complete_i), .tx_start_o(tx_start_o),
		.tx_fifo_flush_o(tx_fifo_flush_o), .txf_empty_i(txf_empty_i),
		.tx_stat_pend_i(tx_stat_pend_i), .tx_clk_ok_i(tx_clk_ok_i), .rxd_req_o(rxd_req_o),
		.rxd_valid_i(rxd_valid_i), .rxd_owned_i(rxd_owned_i),
		.rx_frame_start_i(rx_frame_start_i), .rx_frame_end_i(rx_frame_end_i),
		.rx_status_i(rx_status_i), .rx_pos_o(rx_pos_o), .rx_drop_o(rx_drop_o),
		.rx_flush_o(rx_flush_o), .rx_level_i(rx_level_i), .rx_complete_i(rx_complete_i),
		.rx_req_o(rx_req_o), .rx_fill_i(rx_fill_i), .flow_on_o(flow_on_o));
	edmoc_host_model edmoc_host_model_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.txd_req_i(txd_req_o), .rxd_req_i(rxd_req_o), .tx_own_i(tx_own), .rx_own_i(rx_own),
		.lat_i(lat), .txd_valid_o(txd_valid_i), .txd_owned_o(txd_owned_i),
		.rxd_valid_o(rxd_valid_i), .rxd_owned_o(rxd_owned_i));
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = !ref_clk_i;
	end
	task automatic wrap_up();
		if (fail_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : wt
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic pulse_rx(input logic s, input logic e);
		@(posedge ref_clk_i);
		rx_frame_start_i <= s;
		rx_frame_end_i <= e;
		@(posedge ref_clk_i);
		rx_frame_start_i <= 1'b0;
		rx_frame_end_i <= 1'b0;
		#1;
	endtask : pulse_rx
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end
	initial begin
		{nrst_i, wr_i, rd_i, tx_queued_i, tx_frame_done_i, tx_done_irq_i} = '0;
		{tx_complete_i, txf_empty_i, tx_stat_pend_i, rx_frame_start_i} = '0;
		{rx_frame_end_i, rx_complete_i, tx_own, rx_own} = '0;
		{addr_i, wdata_i, tx_level_i, rx_level_i, rx_fill_i, rx_status_i} = '0;
		ce_i = 1'b1;
		tx_clk_ok_i = 1'b1;
		lat = 4'h3;
		repeat (12) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		rd(MODE_ADDR, v);
		chk(v, MODE_RESET);
		wr(MODE_ADDR, 32'hffefdffd);
		rd(MODE_ADDR, v);
		chk(v, MODE_RW_MASK & 32'hffefdffd);
		// Clock enable low: the write is not taken
		@(posedge ref_clk_i);
		ce_i <= 1'b0;
		wr(MODE_ADDR, 32'h0);
		ce_i <= 1'b1;
		rd(MODE_ADDR, v);
		chk(v, MODE_RW_MASK & 32'hffefdffd);
		rd(16'h1030, v);
		chk(v, 32'h0);
		// Transmit start on a host-owned descriptor, then resume and stop
		wr(MODE_ADDR, 32'h2000);
		wt(10);
		rd(STAT_ADDR, v);
		chk(32'(v[2]), 32'h1);
		chk(32'(v[22:20]), 32'h6);
		wr(STAT_ADDR, 32'h4);
		rd(STAT_ADDR, v);
		chk(32'(v[2]), 32'h0);
		@(posedge ref_clk_i);
		tx_own <= 1'b1;
		lat <= 4'h0;
		wr(TXPOLL_ADDR, 32'h0);
		wt(8);
		rd(STAT_ADDR, v);
		chk(32'(v[22:20]), 32'h3);
		for (int f = 0; f < 2; f++) begin
			@(posedge ref_clk_i);
			tx_queued_i <= 1'b1;
			@(posedge ref_clk_i);
			tx_queued_i <= 1'b0;
			wt(3);
			chk(32'(tx_pos_o), 32'(f + 1));
			@(posedge ref_clk_i);
			tx_frame_done_i <= 1'b1;
			tx_done_irq_i <= (f == 0);
			@(posedge ref_clk_i);
			tx_frame_done_i <= 1'b0;
			wt(8);
			rd(STAT_ADDR, v);
			chk(32'(v[0]), 32'(f == 0));
			chk(32'(v[22:20]), (f == 0) ? 32'h3 : 32'h0);
			chk(32'(v[1]), 32'(f == 1));
			wr(STAT_ADDR, 32'h1);
			wr(MODE_ADDR, 32'h0);
			wt(4);
			rd(STAT_ADDR, v);
			chk(32'(v[22:20]), (f == 0) ? 32'h3 : 32'h0);
		end
		// Overlap: next descriptor fetched before the frame's status
		wr(MODE_ADDR, 32'h2004);
		wt(4);
		@(posedge ref_clk_i);
		tx_queued_i <= 1'b1;
		lat <= 4'hf;
		@(posedge ref_clk_i);
		tx_queued_i <= 1'b0;
		rd(STAT_ADDR, v);
		chk(32'(v[22:20]), 32'h1);
		chk(32'(tx_pos_o), 32'h3);
		wr(MODE_ADDR, 32'h0);
		lat <= 4'h0;
		wt(2);
		rd(STAT_ADDR, v);
		chk(32'(v[22:20]), 32'h0);
		// Receive start with no descriptor, then stop from suspend
		wr(MODE_ADDR, 32'h2);
		wt(10);
		rd(STAT_ADDR, v);
		chk(32'(v[7]), 32'h1);
		chk(32'(v[19:17]), 32'h4);
		wr(MODE_ADDR, 32'h0);
		wt(4);
		rd(STAT_ADDR, v);
		chk(32'(v[8]), 32'h1);
		chk(32'(v[19:17]), 32'h0);
		// Frames ending without a descriptor are flushed unless kept
		wr(MODE_ADDR, 32'h2);
		wt(5);
		pulse_rx(1'b0, 1'b1);
		chk(32'(rx_flush_o), 32'h1);
		wr(MODE_ADDR, 32'h1000002);
		pulse_rx(1'b0, 1'b1);
		chk(32'(rx_flush_o), 32'h0);
		// Resume on poll, transfer a frame, stop only after it ends
		@(posedge ref_clk_i);
		rx_own <= 1'b1;
		wr(RXPOLL_ADDR, 32'h0);
		wt(4);
		pulse_rx(1'b1, 1'b0);
		wr(MODE_ADDR, 32'h0);
		rd(STAT_ADDR, v);
		chk(32'(v[19:17]), 32'h7);
		pulse_rx(1'b0, 1'b1);
		wt(6);
		rd(STAT_ADDR, v);
		chk(32'(v[19:17]), 32'h0);
		chk(32'(rx_pos_o), 32'h1);
		// Transmit threshold codes
		for (int i = 0; i < 8; i++) begin
			wr(MODE_ADDR, 32'(i) << B_TTC_LO);
			for (int j = 0; j < 2; j++) begin
				@(posedge ref_clk_i);
				tx_level_i <= 12'(tt[i] + j);
				wt(2);
				chk(32'(tx_start_o), 32'(j));
			end
		end
		wr(MODE_ADDR, 32'h200000);
		wt(2);
		chk(32'(tx_start_o), 32'h0);
		@(posedge ref_clk_i);
		tx_complete_i <= 1'b1;
		wt(2);
		chk(32'(tx_start_o), 32'h1);
		// Receive threshold codes
		for (int i = 0; i < 4; i++) begin
			wr(MODE_ADDR, 32'(i) << B_RTC_LO);
			for (int j = 0; j < 2; j++) begin
				@(posedge ref_clk_i);
				rx_level_i <= 13'(rr[i] + j);
				wt(2);
				chk(32'(rx_req_o), 32'(j));
			end
		end
		wr(MODE_ADDR, 32'h2000000);
		wt(2);
		chk(32'(rx_req_o), 32'h0);
		@(posedge ref_clk_i);
		rx_complete_i <= 1'b1;
		wt(2);
		chk(32'(rx_req_o), 32'h1);
		// Fill-level flow control with trigger at 3 KB and release at 2 KB
		wr(MODE_ADDR, 32'h900);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			rx_fill_i <= (i == 0) ? 13'd3071 : (i == 1) ? 13'd3072 : (i == 2) ? 13'd2049 : 13'd2048;
			wt(3);
			chk(32'(flow_on_o), 32'(i == 1 || i == 2));
		end
		@(posedge ref_clk_i);
		rx_fill_i <= 13'd4000;
		wr(MODE_ADDR, 32'h0);
		wt(3);
		chk(32'(flow_on_o), 32'h0);
		// Frame drop decisions
		for (int i = 0; i < 8; i++) begin
			wr(MODE_ADDR, dm[i]);
			rx_status_i <= edmoc_rxst_t'(ds[i]);
			pulse_rx(1'b0, 1'b1);
			chk(32'(rx_drop_o), 32'(de[i]));
		end
		// Flush waits for an empty FIFO and no pending status
		wr(MODE_ADDR, 32'h100000);
		@(posedge ref_clk_i);
		tx_stat_pend_i <= 1'b1;
		txf_empty_i <= 1'b1;
		wt(4);
		chk(32'(tx_fifo_flush_o), 32'h1);
		@(posedge ref_clk_i);
		tx_stat_pend_i <= 1'b0;
		wt(4);
		chk(32'(tx_fifo_flush_o), 32'h0);
		rd(MODE_ADDR, v);
		chk(32'(v[B_FLUSH]), 32'h0);
		wrap_up();
	end
endmodule : test_eth_dma_operation_mode_control
`default_nettype wire
